/* twrs_pkg.sv */
// shared constants and types for the two-wire register slave
package twrs_pkg;

   // address bytes include the direction bit in bit 0
   localparam logic [7:0]  ADDR_BYTE_DEFAULT = 8'h20;
   localparam logic [7:0]  ADDR_BYTE_SELECT  = 8'h30;
   localparam int          DIR_BIT           = 0;
   localparam logic        DIR_WRITE         = 1'b0;
   localparam logic        DIR_READ          = 1'b1;

   // alternate slave address register, low byte holds {address[6:0], enable}
   localparam logic [15:0] ALT_SLAVE_ADDR_HI = 16'h31fc;
   localparam logic [15:0] ALT_SLAVE_ADDR_LO = 16'h31fd;
   localparam int          ALT_EN_BIT        = 0;
   localparam logic [7:0]  ALT_RESET         = 8'h00;

   localparam logic [7:0]  REG_RESET         = 8'h00;
   localparam logic [15:0] REG_ADDR_RESET    = 16'h0000;
   localparam logic [3:0]  BITS_PER_BYTE     = 4'h8;
   localparam logic [1:0]  IDX_ADDR_HI       = 2'h0;
   localparam logic [1:0]  IDX_ADDR_LO       = 2'h1;
   localparam logic [1:0]  IDX_DATA          = 2'h2;

   // one register access handed from the link side to the system side
   typedef struct packed {
      logic        wr;
      logic [15:0] addr;
      logic [7:0]  data;
   } twrs_acc_t;

   typedef enum logic [6:0] {
      ST_IDLE     = 7'b0000001,
      ST_ADDR     = 7'b0000010,
      ST_ADDR_ACK = 7'b0000100,
      ST_RX       = 7'b0001000,
      ST_RX_ACK   = 7'b0010000,
      ST_TX       = 7'b0100000,
      ST_TX_ACK   = 7'b1000000
   } twrs_state_t;

endpackage

/* twrs_slave.sv */
// two-wire serial register slave: link engine plus register array
// How it works
// - clock line is input only, never driven
// - data line only pulled low or released
// - both lines high means bus idle
// - data falls while clock high: start
// - start without stop accepted as restart
// - data rises while clock high: stop
// - eight bits MSB first, then acknowledge
// - one bit per clock, sampled clock high
// - first byte: address 7:1, direction 0
// - default address bytes 0x20 and 0x21
// - select pin enabled and high: 0x30 and 0x31
// - programmed alternate address answered instead of the default and select addresses
// - acknowledge only on matching address
// - transmitter releases, receiver pulls low
// - master no-acknowledge ends read
// - two register address bytes, each acknowledged
// - write data stored, acknowledged
// - random read via write then restart
// - register address increments every data byte
// - reset returns registers to defaults
// - bare read starts at current address
// - sequential writes to successive addresses
`timescale 1ns/10ps
module twrs_slave
   import twrs_pkg::*;
#(
   parameter int REG_AW = 8
) (
   input  wire logic              I_CLK,
   input  wire logic              I_RST,
   input  wire logic              I_LINK_CLK,
   input  wire logic              I_SERIAL_BUS_CLK,
   input  wire logic              I_SERIAL_BUS_DATA_IO,
   output logic                   O_SERIAL_BUS_DATA_IO,
   output logic                   O_SERIAL_BUS_DATA_IO_OE_N,
   input  wire logic              I_BUS_ADDRESS_SELECT,
   input  wire logic              I_BUS_ADDRESS_SELECT_EN,
   input  wire logic [REG_AW-1:0] I_CORE_ADDR,
   output logic [7:0]             O_CORE_RDATA,
   output logic                   O_WR_STROBE,
   output twrs_acc_t              O_WR_INFO
);

   // ---------------- link clock domain ----------------
   logic        lrst_s1_q;
   logic        lrst_q;
   logic        scl_s1_q;
   logic        scl_s2_q;
   logic        scl_p_q;
   logic        sda_s1_q;
   logic        sda_s2_q;
   logic        sda_p_q;
   logic        sel_s1_q;
   logic        sel_s2_q;
   logic        selen_s1_q;
   logic        selen_s2_q;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_det;
   logic        stop_det;
   twrs_state_t state_q;
   logic [3:0]  bit_cnt_q;
   logic [7:0]  shift_q;
   logic [1:0]  byte_idx_q;
   logic        dir_q;
   logic        mst_ack_q;
   logic [15:0] reg_addr_q;
   logic [7:0]  alt_q;
   logic        pull_low_q;
   logic        req_tgl_q;
   twrs_acc_t   req_q;
   logic        ack_s1_q;
   logic        ack_s2_q;
   logic        ack_s3_q;
   logic [7:0]  rdata_l_q;
   logic [7:0]  rx_byte;
   logic        addr_match;
   logic        byte_end;
   logic        issue_rd;
   logic        issue_wr;
   // system clock registers, read here only behind the toggle sync
   logic        ack_tgl_q;
   logic [7:0]  rd_data_q;

   // link reset: asserts at once, releases on the link clock
   always_ff @(posedge I_LINK_CLK or posedge I_RST) begin
      if (I_RST) begin
         lrst_s1_q <= 1'b1;
         lrst_q    <= 1'b1;
      end else begin
         lrst_s1_q <= 1'b0;
         lrst_q    <= lrst_s1_q;
      end
   end

   // bus pins are asynchronous to the link clock
   always_ff @(posedge I_LINK_CLK or posedge lrst_q) begin
      if (lrst_q) begin
         scl_s1_q   <= 1'b1;
         scl_s2_q   <= 1'b1;
         scl_p_q    <= 1'b1;
         sda_s1_q   <= 1'b1;
         sda_s2_q   <= 1'b1;
         sda_p_q    <= 1'b1;
         sel_s1_q   <= 1'b0;
         sel_s2_q   <= 1'b0;
         selen_s1_q <= 1'b0;
         selen_s2_q <= 1'b0;
      end else begin
         scl_s1_q   <= I_SERIAL_BUS_CLK;
         scl_s2_q   <= scl_s1_q;
         scl_p_q    <= scl_s2_q;
         sda_s1_q   <= I_SERIAL_BUS_DATA_IO;
         sda_s2_q   <= sda_s1_q;
         sda_p_q    <= sda_s2_q;
         sel_s1_q   <= I_BUS_ADDRESS_SELECT;
         sel_s2_q   <= sel_s1_q;
         selen_s1_q <= I_BUS_ADDRESS_SELECT_EN;
         selen_s2_q <= selen_s1_q;
      end
   end

   assign scl_rise  = scl_s2_q & ~scl_p_q;
   assign scl_fall  = ~scl_s2_q & scl_p_q;
   assign start_det = scl_s2_q & scl_p_q & sda_p_q & ~sda_s2_q;
   assign stop_det  = scl_s2_q & scl_p_q & ~sda_p_q & sda_s2_q;
   assign rx_byte   = shift_q;
   assign byte_end  = scl_fall && (bit_cnt_q == BITS_PER_BYTE);

   // alternate address wins, then the select pin, then the default
   always_comb begin
      logic [6:0] act;
      act = ADDR_BYTE_DEFAULT[7:1];
      if (alt_q[ALT_EN_BIT]) begin
         act = alt_q[7:1];
      end else if (selen_s2_q && sel_s2_q) begin
         act = ADDR_BYTE_SELECT[7:1];
      end
      addr_match = (rx_byte[7:1] == act);
   end

   assign issue_rd = (state_q == ST_ADDR && byte_end && addr_match
                      && rx_byte[DIR_BIT] == DIR_READ)
                     || (state_q == ST_TX && byte_end);
   assign issue_wr = state_q == ST_RX && byte_end && byte_idx_q >= IDX_DATA;

   // protocol sequencer
   always_ff @(posedge I_LINK_CLK or posedge lrst_q) begin
      if (lrst_q) begin
         state_q    <= ST_IDLE;
         bit_cnt_q  <= 4'h0;
         shift_q    <= 8'h00;
         byte_idx_q <= IDX_ADDR_HI;
         dir_q      <= DIR_WRITE;
         mst_ack_q  <= 1'b0;
         pull_low_q <= 1'b0;
      end else if (start_det) begin
         state_q    <= ST_ADDR;
         bit_cnt_q  <= 4'h0;
         pull_low_q <= 1'b0;
      end else if (stop_det) begin
         state_q    <= ST_IDLE;
         bit_cnt_q  <= 4'h0;
         pull_low_q <= 1'b0;
      end else begin
         case (state_q)
            ST_ADDR, ST_RX: begin
               if (scl_rise && bit_cnt_q != BITS_PER_BYTE) begin
                  shift_q   <= {shift_q[6:0], sda_s2_q};
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end else if (byte_end) begin
                  bit_cnt_q <= 4'h0;
                  if (state_q == ST_RX) begin
                     pull_low_q <= 1'b1;
                     state_q    <= ST_RX_ACK;
                     if (byte_idx_q != IDX_DATA) begin
                        byte_idx_q <= byte_idx_q + 2'h1;
                     end
                  end else if (addr_match) begin
                     pull_low_q <= 1'b1;
                     dir_q      <= rx_byte[DIR_BIT];
                     byte_idx_q <= IDX_ADDR_HI;
                     state_q    <= ST_ADDR_ACK;
                  end else begin
                     state_q <= ST_IDLE;
                  end
               end
            end
            ST_ADDR_ACK, ST_RX_ACK: begin
               if (scl_fall) begin
                  if (dir_q == DIR_READ && state_q == ST_ADDR_ACK) begin
                     // prefetched byte from the current address
                     shift_q    <= rdata_l_q;
                     pull_low_q <= ~rdata_l_q[7];
                     state_q    <= ST_TX;
                  end else begin
                     pull_low_q <= 1'b0;
                     state_q    <= ST_RX;
                  end
               end
            end
            ST_TX: begin
               if (scl_rise) begin
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end else if (byte_end) begin
                  pull_low_q <= 1'b0;
                  bit_cnt_q  <= 4'h0;
                  state_q    <= ST_TX_ACK;
               end else if (scl_fall) begin
                  shift_q    <= {shift_q[6:0], 1'b0};
                  pull_low_q <= ~shift_q[6];
               end
            end
            ST_TX_ACK: begin
               if (scl_rise) begin
                  mst_ack_q <= ~sda_s2_q;
               end else if (scl_fall) begin
                  if (mst_ack_q) begin
                     shift_q    <= rdata_l_q;
                     pull_low_q <= ~rdata_l_q[7];
                     state_q    <= ST_TX;
                  end else begin
                     state_q <= ST_IDLE;
                  end
               end
            end
            ST_IDLE: begin
               pull_low_q <= 1'b0;
            end
            default: begin
               state_q    <= ST_IDLE;
               pull_low_q <= 1'b0;
            end
         endcase
      end
   end

   // internal register address and alternate slave address
   always_ff @(posedge I_LINK_CLK or posedge lrst_q) begin
      if (lrst_q) begin
         reg_addr_q <= REG_ADDR_RESET;
         alt_q      <= ALT_RESET;
      end else if (state_q == ST_RX && byte_end && !start_det && !stop_det) begin
         case (byte_idx_q)
            IDX_ADDR_HI: reg_addr_q[15:8] <= rx_byte;
            IDX_ADDR_LO: reg_addr_q[7:0]  <= rx_byte;
            default: begin
               reg_addr_q <= reg_addr_q + 16'h0001;
               if (reg_addr_q == ALT_SLAVE_ADDR_LO) begin
                  alt_q <= rx_byte;
               end
            end
         endcase
      end else if (state_q == ST_TX && byte_end && !start_det && !stop_det) begin
         reg_addr_q <= reg_addr_q + 16'h0001;
      end
   end

   // access request toward the system side, toggle handshake
   always_ff @(posedge I_LINK_CLK or posedge lrst_q) begin
      if (lrst_q) begin
         req_tgl_q <= 1'b0;
         req_q     <= '0;
      end else if (!start_det && !stop_det && (issue_wr || issue_rd)) begin
         req_tgl_q <= ~req_tgl_q;
         req_q.wr  <= issue_wr;
         req_q.data <= rx_byte;
         // a read after a byte fetches the next address ahead of time
         req_q.addr <= (state_q == ST_TX) ? reg_addr_q + 16'h0001 : reg_addr_q;
      end
   end

   // read data returns with the acknowledge toggle
   always_ff @(posedge I_LINK_CLK or posedge lrst_q) begin
      if (lrst_q) begin
         ack_s1_q  <= 1'b0;
         ack_s2_q  <= 1'b0;
         ack_s3_q  <= 1'b0;
         rdata_l_q <= REG_RESET;
      end else begin
         ack_s1_q <= ack_tgl_q;
         ack_s2_q <= ack_s1_q;
         ack_s3_q <= ack_s2_q;
         if (ack_s2_q != ack_s3_q) begin
            rdata_l_q <= rd_data_q;
         end
      end
   end

   // open drain: output is always low, enable decides
   assign O_SERIAL_BUS_DATA_IO      = 1'b0;
   assign O_SERIAL_BUS_DATA_IO_OE_N = ~pull_low_q;
   // the clock line has no driver at all in this block

   // ---------------- system clock domain ----------------
   logic              req_s1_q;
   logic              req_s2_q;
   logic              req_s3_q;
   logic [7:0]        regs_q [2**REG_AW];
   logic [REG_AW-1:0] acc_idx;

   // request fields are held steady across the handshake, no resync needed
   assign acc_idx = req_q.addr[REG_AW-1:0];

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         req_s1_q <= 1'b0;
         req_s2_q <= 1'b0;
         req_s3_q <= 1'b0;
      end else begin
         req_s1_q <= req_tgl_q;
         req_s2_q <= req_s1_q;
         req_s3_q <= req_s2_q;
      end
   end

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         for (int i = 0; i < 2**REG_AW; i++) begin
            regs_q[i] <= REG_RESET;
         end
      end else if (req_s2_q != req_s3_q && req_q.wr) begin
         regs_q[acc_idx] <= req_q.data;
      end
   end

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         ack_tgl_q   <= 1'b0;
         rd_data_q   <= REG_RESET;
         O_WR_STROBE <= 1'b0;
         O_WR_INFO   <= '0;
      end else begin
         O_WR_STROBE <= 1'b0;
         if (req_s2_q != req_s3_q) begin
            ack_tgl_q <= ~ack_tgl_q;
            if (req_q.wr) begin
               O_WR_STROBE <= 1'b1;
               O_WR_INFO   <= req_q;
            end else begin
               rd_data_q <= regs_q[acc_idx];
            end
         end
      end
   end

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_CORE_RDATA <= REG_RESET;
      end else begin
         O_CORE_RDATA <= regs_q[I_CORE_ADDR];
      end
   end

endmodule // twrs_slave

/* twrs_master.sv */
// bus master model that clocks the two-wire link and drives its data line
`timescale 1ns/10ps
module twrs_master (
   output logic      o_scl,
   output logic      o_sda,
   input  wire logic i_sda
);
   // quarter bit, about 333 kHz, well inside what the link sampler tracks
   localparam time Q = 750ns;
   initial begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end
   task automatic start();
      #Q o_sda = 1'b1;
      #Q o_scl = 1'b1;
      #Q o_sda = 1'b0;
      #Q o_scl = 1'b0;
   endtask
   task automatic stop();
      #Q o_sda = 1'b0;
      #Q o_scl = 1'b1;
      #Q o_sda = 1'b1;
      #Q;
   endtask
   // bits from bit 8 down; a 1 releases the line so the device may answer
   task automatic bits(input logic [8:0] o, input int n, output logic [8:0] i);
      i = '1;
      for (int k = 8; k > 8 - n; k--) begin
         #Q o_sda = o[k];
         #Q o_scl = 1'b1;
         #Q i[k] = i_sda;
         #Q o_scl = 1'b0;
      end
   endtask
endmodule // twrs_master

/* twrs_slave_chk.sv */
// concurrent checks on the two-wire register slave ports
`timescale 1ns/10ps
module twrs_slave_chk
   import twrs_pkg::*;
#(
   parameter int REG_AW = 8
) (
   input wire logic              I_CLK,
   input wire logic              I_RST,
   input wire logic              I_LINK_CLK,
   input wire logic              I_SERIAL_BUS_CLK,
   input wire logic              O_SERIAL_BUS_DATA_IO,
   input wire logic              O_SERIAL_BUS_DATA_IO_OE_N,
   input wire logic [REG_AW-1:0] I_CORE_ADDR,
   input wire logic [7:0]        O_CORE_RDATA,
   input wire logic              O_WR_STROBE,
   input wire twrs_acc_t         O_WR_INFO
);
   // core port parked on the stored address for three cycles after a store
   sequence s_wr_held;
      O_WR_STROBE ##1 (I_CORE_ADDR == O_WR_INFO.addr[REG_AW-1:0]) [*3];
   endsequence
   property p_low_only;
      @(posedge I_LINK_CLK) disable iff (I_RST) !O_SERIAL_BUS_DATA_IO;
   endproperty
   a_low_only: assert property (p_low_only) else $error("data driven high");
   property p_scl_low;
      @(posedge I_LINK_CLK) disable iff (I_RST) $changed(O_SERIAL_BUS_DATA_IO_OE_N) |-> !I_SERIAL_BUS_CLK;
   endproperty
   a_scl_low: assert property (p_scl_low) else $error("data moved, clock high");
   property p_ack_hold;
      @(posedge I_LINK_CLK) disable iff (I_RST)
         $fell(O_SERIAL_BUS_DATA_IO_OE_N) |-> !O_SERIAL_BUS_DATA_IO_OE_N [*8];
   endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("pull-low too short");
   property p_one_strobe;
      @(posedge I_CLK) disable iff (I_RST) O_WR_STROBE |=> !O_WR_STROBE [*8];
   endproperty
   a_one_strobe: assert property (p_one_strobe) else $error("strobe too long");
   property p_info_wr;
      @(posedge I_CLK) disable iff (I_RST) O_WR_STROBE |-> O_WR_INFO.wr;
   endproperty
   a_info_wr: assert property (p_info_wr) else $error("store not marked write");
   property p_info_hold;
      @(posedge I_CLK) disable iff (I_RST) !O_WR_STROBE |-> $stable(O_WR_INFO);
   endproperty
   a_info_hold: assert property (p_info_hold) else $error("info moved alone");
   property p_core_rd;
      @(posedge I_CLK) disable iff (I_RST) s_wr_held |-> O_CORE_RDATA == O_WR_INFO.data;
   endproperty
   a_core_rd: assert property (p_core_rd) else $error("stored byte not read back");
   property p_rst_vals;
      @(posedge I_CLK) disable iff (I_RST) $fell(I_RST) |->
         O_SERIAL_BUS_DATA_IO_OE_N && !O_WR_STROBE && O_WR_INFO == '0;
   endproperty
   a_rst_vals: assert property (p_rst_vals) else $error("reset state wrong");
endmodule // twrs_slave_chk
bind twrs_slave twrs_slave_chk #(.REG_AW(REG_AW)) twrs_slave_chk_inst (.*);

/* twrs_slave_test.sv */
// self-checking bench for the two-wire register slave
`timescale 1ns/10ps
module twrs_slave_test;
   import twrs_pkg::*;
   logic        clk, lclk, rst, sel, sel_en, scl, m_sda, o_data, oe_n, wr_strobe;
   logic [7:0]  core_addr, core_rdata, d;
   logic [8:0]  rx;
   logic [7:0]  mem [256];
   logic [24:0] exp_q [$];
   twrs_acc_t   wr_info;
   int          mismatches, num_checks, seed, cur;
   wire         sda = m_sda & (oe_n | o_data); // pull-up unless pulled low
   twrs_slave #(.REG_AW(8)) twrs_slave_inst (.I_CLK(clk), .I_RST(rst), .I_LINK_CLK(lclk),
      .I_SERIAL_BUS_CLK(scl), .I_SERIAL_BUS_DATA_IO(sda), .O_SERIAL_BUS_DATA_IO(o_data),
      .O_SERIAL_BUS_DATA_IO_OE_N(oe_n), .I_BUS_ADDRESS_SELECT(sel),
      .I_BUS_ADDRESS_SELECT_EN(sel_en), .I_CORE_ADDR(core_addr),
      .O_CORE_RDATA(core_rdata), .O_WR_STROBE(wr_strobe), .O_WR_INFO(wr_info));
   twrs_master twrs_master_inst (.o_scl(scl), .o_sda(m_sda), .i_sda(sda));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // offset so link edges never coincide with system clock edges
   initial begin
      lclk = 1'b0;
      #13;
      forever #40 lclk = ~lclk;
   end
   task automatic chk(input logic [24:0] got, input logic [24:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   always @(negedge clk) begin
      if (wr_strobe === 1'b1) chk(wr_info, exp_q.size() > 0 ? exp_q.pop_front() : '0);
   end
   task automatic send(input logic [7:0] b, input logic ack);
      twrs_master_inst.bits({b, 1'b1}, 9, rx);
      chk(rx[0], !ack);
   endtask
   task automatic probe(input logic [7:0] b, input logic ack);
      twrs_master_inst.start();
      send(b, ack);
      twrs_master_inst.stop();
   endtask
   task automatic setup(input logic [7:0] wa, input logic [15:0] a);
      twrs_master_inst.start();
      send(wa, 1'b1);
      send(a[15:8], 1'b1);
      send(a[7:0], 1'b1);
      cur = a;
   endtask
   task automatic wr(input logic [7:0] wa, input logic [15:0] a, input int n, input logic [7:0] d0);
      setup(wa, a);
      for (int k = 0; k < n; k++) begin
         d = (k != 0) ? 8'($random(seed)) : d0;
         mem[cur[7:0]] = d;
         exp_q.push_back({1'b1, cur[15:0], d});
         @(negedge clk) core_addr = cur[7:0];
         send(d, 1'b1);
         cur++;
      end
      twrs_master_inst.stop();
   endtask
   task automatic rd(input int n);
      twrs_master_inst.start();
      send(8'h21, 1'b1);
      for (int k = 0; k < n; k++) begin
         twrs_master_inst.bits({8'hff, k == n - 1}, 9, rx);
         chk(rx[8:1], mem[cur[7:0]]);
         cur++;
      end
      twrs_master_inst.stop();
   endtask
   task automatic do_reset();
      @(negedge clk) rst = 1'b1;
      foreach (mem[i]) mem[i] = REG_RESET;
      cur = 0;
      // long enough for three link clock edges
      repeat (13) @(negedge clk);
      rst = 1'b0;
      repeat (30) @(negedge clk);
   endtask
   task automatic sweep();
      for (int k = 0; k < 256; k++) begin
         @(negedge clk) core_addr = k[7:0];
         @(negedge clk) chk(core_rdata, mem[k]);
      end
   endtask
   initial begin
      #1600us;
      mismatches++;
      report_and_stop();
   end
   initial begin
      {sel, sel_en, core_addr} = 10'h000;
      rst = 1'b1;
      mismatches = 0;
      num_checks = 0;
      seed = 32'h723f7e65;
      do_reset();
      rd(1);
      wr(8'h20, 16'h0010, 3, 8'h5a);
      setup(8'h20, 16'h0010);
      rd(3);
      rd(2);
      probe(8'h40, 1'b0);
      for (int k = 0; k < 4; k++) begin
         @(negedge clk) {sel_en, sel} = k[1:0];
         repeat (10) @(negedge clk);
         probe(8'h20, k != 3);
         probe(8'h30, k == 3);
      end
      @(negedge clk) {sel_en, sel} = 2'b00;
      twrs_master_inst.start();
      twrs_master_inst.bits(9'h0ff, 4, rx);
      wr(8'h20, 16'h0120, 2, 8'($random(seed)));
      sweep();
      wr(8'h20, ALT_SLAVE_ADDR_LO, 1, 8'hab);
      probe(8'haa, 1'b1);
      probe(8'h20, 1'b0);
      chk(25'(exp_q.size()), 25'h0);
      do_reset();
      probe(8'h20, 1'b1);
      probe(8'haa, 1'b0);
      sweep();
      report_and_stop();
   end
endmodule // twrs_slave_test
